/* File: contact_io_test_override.sv */
// Contact I/O test override top with AXI4-Lite settings slave
`timescale 1ns/1ps
module contact_io_test_override (
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    // AXI4-Lite write address
    input  wire logic [7:0]  AWADDR_I,
    input  wire logic        AWVALID_I,
    output logic             AWREADY_O,
    // AXI4-Lite write data
    input  wire logic [31:0] WDATA_I,
    input  wire logic [3:0]  WSTRB_I,
    input  wire logic        WVALID_I,
    output logic             WREADY_O,
    // AXI4-Lite write response
    output logic [1:0]       BRESP_O,
    output logic             BVALID_O,
    input  wire logic        BREADY_I,
    // AXI4-Lite read address
    input  wire logic [7:0]  ARADDR_I,
    input  wire logic        ARVALID_I,
    output logic             ARREADY_O,
    // AXI4-Lite read data
    output logic [31:0]      RDATA_O,
    output logic [1:0]       RRESP_O,
    output logic             RVALID_O,
    input  wire logic        RREADY_I,
    // Contact inputs: sensed in, effective out
    input  wire logic [15:0] CONTACT_SENSED_I,
    output logic [15:0]      CONTACT_STATE_O,
    // Contact outputs: normal drive in, final drive out
    input  wire logic [15:0] OUT_NORMAL_I,
    output logic [15:0]      CONTACT_DRIVE_O,
    // Test mode indicator
    output logic             TEST_LED_O
);

    localparam int DW = contact_io_pkg::DATA_W;
    localparam int AW = contact_io_pkg::ADDR_W;

    // Settings registers
    logic [DW-1:0] ctrl_reg;
    logic [DW-1:0] in_force_reg;
    logic [DW-1:0] out_force_reg;

    // Write channel state
    logic          awready_reg;
    logic          wready_reg;
    logic          aw_held_reg;
    logic          w_held_reg;
    logic [AW-1:0] awaddr_reg;
    logic [DW-1:0] wdata_reg;
    logic [3:0]    wstrb_reg;
    logic          bvalid_reg;
    logic [1:0]    bresp_reg;

    // Read channel state
    logic          arready_reg;
    logic          rvalid_reg;
    logic [DW-1:0] rdata_reg;
    logic [1:0]    rresp_reg;

    // Status
    logic          led_reg;
    logic          status_active;
    logic          in_forced;
    logic          out_forced;
    logic [15:0]   state_w;
    logic [15:0]   drive_w;

    // Handshakes and the merged write beat
    logic          aw_hs;
    logic          w_hs;
    logic          wr_fire;
    logic          ar_hs;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic [3:0]    wr_strb;
    logic          wr_mapped;
    logic          master_drop;

    // Byte-lane merge of a write into an old value
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_v,
                                            input logic [DW-1:0] new_v,
                                            input logic [3:0]    strb);
        logic [DW-1:0] res;
        res = old_v;
        for (int b = 0; b < contact_io_pkg::STRB_W; b++) begin
            if (strb[b])
                res[b*8 +: 8] = new_v[b*8 +: 8];
        end
        return res;
    endfunction : merge

    // Address decode shared by read and write
    function automatic logic is_mapped(input logic [AW-1:0] a);
        case (a)
            contact_io_pkg::OFS_CTRL,
            contact_io_pkg::OFS_IN_FORCE,
            contact_io_pkg::OFS_OUT_FORCE,
            contact_io_pkg::OFS_STATUS,
            contact_io_pkg::OFS_IN_SENSED,
            contact_io_pkg::OFS_IN_EFF,
            contact_io_pkg::OFS_OUT_NORM,
            contact_io_pkg::OFS_OUT_DRIVE: is_mapped = 1'b1;
            default:                       is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    // Handshake terms
    assign aw_hs = AWVALID_I & awready_reg;
    assign w_hs  = WVALID_I & wready_reg;
    assign ar_hs = ARVALID_I & arready_reg;

    // Address and data may arrive in either order; a held beat wins
    assign wr_addr   = aw_held_reg ? awaddr_reg : AWADDR_I;
    assign wr_data   = w_held_reg ? wdata_reg : WDATA_I;
    assign wr_strb   = w_held_reg ? wstrb_reg : WSTRB_I;
    assign wr_fire   = (aw_held_reg | aw_hs) & (w_held_reg | w_hs) & ~bvalid_reg;
    assign wr_mapped = is_mapped(wr_addr);

    // Software clearing the master enable ends the whole test session
    assign master_drop = wr_fire && wr_addr == contact_io_pkg::OFS_CTRL && wr_strb[0]
                         && !wr_data[contact_io_pkg::CTRL_TEST_BIT]
                         && ctrl_reg[contact_io_pkg::CTRL_TEST_BIT];

    // Test active flag
    assign in_forced     = contact_io_pkg::in_any_forced(in_force_reg);
    assign out_forced    = contact_io_pkg::out_any_forced(out_force_reg);
    assign status_active = ctrl_reg[contact_io_pkg::CTRL_TEST_BIT]
                           | in_forced | out_forced; // R11

    // Write address channel; ready returns only after the response
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            awready_reg <= 1'b1;
            aw_held_reg <= 1'b0;
            awaddr_reg  <= '0;
        end else if (wr_fire) begin
            awready_reg <= 1'b0;
            aw_held_reg <= 1'b0;
        end else if (aw_hs) begin
            awready_reg <= 1'b0;
            aw_held_reg <= 1'b1;
            awaddr_reg  <= AWADDR_I;
        end else if (bvalid_reg && BREADY_I) begin
            awready_reg <= 1'b1;
        end
    end

    // Write data channel, mirrors the address side
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            wready_reg <= 1'b1;
            w_held_reg <= 1'b0;
            wdata_reg  <= '0;
            wstrb_reg  <= '0;
        end else if (wr_fire) begin
            wready_reg <= 1'b0;
            w_held_reg <= 1'b0;
        end else if (w_hs) begin
            wready_reg <= 1'b0;
            w_held_reg <= 1'b1;
            wdata_reg  <= WDATA_I;
            wstrb_reg  <= WSTRB_I;
        end else if (bvalid_reg && BREADY_I) begin
            wready_reg <= 1'b1;
        end
    end

    // Write response; unmapped offsets answer SLVERR
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= contact_io_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_mapped ? contact_io_pkg::RESP_OKAY
                                    : contact_io_pkg::RESP_SLVERR;
        end else if (BREADY_I) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Master test enable
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            ctrl_reg <= contact_io_pkg::CTRL_RST;
        end else if (wr_fire && wr_addr == contact_io_pkg::OFS_CTRL) begin
            ctrl_reg <= merge(ctrl_reg, wr_data, wr_strb) & 32'h0000_0001; // R1
        end
    end

    // Force selectors; dropping master clears them so all I/O goes normal
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            in_force_reg  <= contact_io_pkg::FORCE_RST;
            out_force_reg <= contact_io_pkg::FORCE_RST;
        end else if (master_drop) begin
            in_force_reg  <= contact_io_pkg::FORCE_RST; // R3
            out_force_reg <= contact_io_pkg::FORCE_RST; // R3
        end else if (wr_fire && wr_addr == contact_io_pkg::OFS_IN_FORCE) begin
            in_force_reg <= merge(in_force_reg, wr_data, wr_strb); // R4
        end else if (wr_fire && wr_addr == contact_io_pkg::OFS_OUT_FORCE) begin
            out_force_reg <= merge(out_force_reg, wr_data, wr_strb); // R7
        end
    end

    // Read channel; data is sampled at the address handshake
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= '0;
            rresp_reg   <= contact_io_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rresp_reg   <= is_mapped(ARADDR_I) ? contact_io_pkg::RESP_OKAY
                                               : contact_io_pkg::RESP_SLVERR;
            case (ARADDR_I)
                contact_io_pkg::OFS_CTRL:      rdata_reg <= ctrl_reg;
                contact_io_pkg::OFS_IN_FORCE:  rdata_reg <= in_force_reg;
                contact_io_pkg::OFS_OUT_FORCE: rdata_reg <= out_force_reg;
                contact_io_pkg::OFS_STATUS: begin
                    rdata_reg <= '0;
                    rdata_reg[contact_io_pkg::ST_ACTIVE_BIT] <= status_active;
                    rdata_reg[contact_io_pkg::ST_IN_BIT]     <= in_forced;
                    rdata_reg[contact_io_pkg::ST_OUT_BIT]    <= out_forced;
                    rdata_reg[contact_io_pkg::ST_MASTER_BIT] <=
                        ctrl_reg[contact_io_pkg::CTRL_TEST_BIT];
                end
                contact_io_pkg::OFS_IN_SENSED: rdata_reg <= {16'h0000, CONTACT_SENSED_I};
                contact_io_pkg::OFS_IN_EFF:    rdata_reg <= {16'h0000, state_w};
                contact_io_pkg::OFS_OUT_NORM:  rdata_reg <= {16'h0000, OUT_NORMAL_I};
                contact_io_pkg::OFS_OUT_DRIVE: rdata_reg <= {16'h0000, drive_w};
                default:                       rdata_reg <= '0;
            endcase
        end else if (rvalid_reg && RREADY_I) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
        end
    end

    // Indicator follows the test active flag, one cycle late
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            led_reg <= 1'b0;
        end else begin
            led_reg <= status_active; // R2
        end
    end

    // Input override path
    input_force_mux u_in (
        .clk_i    (CLK_I),
        .rst_n_i  (RST_N_I),
        .sel_i    (in_force_reg),
        .sensed_i (CONTACT_SENSED_I),
        .state_o  (state_w)
    );

    // Output override path
    output_force_ctl u_out (
        .clk_i    (CLK_I),
        .rst_n_i  (RST_N_I),
        .sel_i    (out_force_reg),
        .normal_i (OUT_NORMAL_I),
        .drive_o  (drive_w)
    );

    // Port drive, all from flip-flops
    assign AWREADY_O       = awready_reg;
    assign WREADY_O        = wready_reg;
    assign BVALID_O        = bvalid_reg;
    assign BRESP_O         = bresp_reg;
    assign ARREADY_O       = arready_reg;
    assign RVALID_O        = rvalid_reg;
    assign RDATA_O         = rdata_reg;
    assign RRESP_O         = rresp_reg;
    assign CONTACT_STATE_O = state_w;
    assign CONTACT_DRIVE_O = drive_w;
    assign TEST_LED_O      = led_reg;

endmodule : contact_io_test_override

/* File: contact_io_pkg.sv */
// Constants and helpers shared by the contact test override block
// Summary of operation
// R1 - While master test enable is set, forced states take precedence over normal I/O.
// R2 - Test indicator output stays lit for as long as test mode is active.
// R3 - Clearing master test enable restores normal operation of every overridden function.
// R4 - Any enabled input force enters test mode and replaces sensed input state.
// R5 - Input force selector: disabled uses sensed state, open gives zero, closed one.
// R6 - Input handling returns to normal only when all input selectors are disabled.
// R7 - Any enabled output force enters test mode, lights indicator, replaces output drive.
// R8 - Output force selector: disabled, energized, de-energized or freeze.
// R9 - Freeze holds the output at its state when freeze was chosen, until changed.
// R10 - Output handling returns to normal only when all output selectors are disabled.
// R11 - Test active is master enable OR any input or output selector not disabled.
// R12 - Frozen value is captured per output on the cycle freeze first becomes active.
package contact_io_pkg;

    // Sizes
    localparam int NUM_IN  = 16;
    localparam int NUM_OUT = 16;
    localparam int SEL_W   = 2;
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int STRB_W  = 4;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_IN_FORCE  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_OUT_FORCE = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_IN_SENSED = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IN_EFF    = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_OUT_NORM  = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_OUT_DRIVE = 8'h1c;

    // Field positions
    localparam int CTRL_TEST_BIT = 0;
    localparam int ST_ACTIVE_BIT = 0;
    localparam int ST_IN_BIT     = 1;
    localparam int ST_OUT_BIT    = 2;
    localparam int ST_MASTER_BIT = 3;

    // Reset values
    localparam logic [DATA_W-1:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] FORCE_RST = 32'h0000_0000;

    // Input force selector codes
    localparam logic [SEL_W-1:0] IN_SEL_OFF    = 2'h0;
    localparam logic [SEL_W-1:0] IN_SEL_OPEN   = 2'h1;
    localparam logic [SEL_W-1:0] IN_SEL_CLOSED = 2'h2;

    // Output force selector codes
    localparam logic [SEL_W-1:0] OUT_SEL_OFF    = 2'h0;
    localparam logic [SEL_W-1:0] OUT_SEL_ENERGY = 2'h1;
    localparam logic [SEL_W-1:0] OUT_SEL_DEENER = 2'h2;
    localparam logic [SEL_W-1:0] OUT_SEL_FREEZE = 2'h3;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // True when any input selector forces open or closed; code 3 counts as disabled
    function automatic logic in_any_forced(input logic [NUM_IN*SEL_W-1:0] sel);
        logic any;
        any = 1'b0;
        for (int i = 0; i < NUM_IN; i++) begin
            if (sel[i*SEL_W +: SEL_W] == IN_SEL_OPEN || sel[i*SEL_W +: SEL_W] == IN_SEL_CLOSED)
                any = 1'b1;
        end
        return any;
    endfunction : in_any_forced

    // True when any output selector is not disabled
    function automatic logic out_any_forced(input logic [NUM_OUT*SEL_W-1:0] sel);
        logic any;
        any = 1'b0;
        for (int i = 0; i < NUM_OUT; i++) begin
            if (sel[i*SEL_W +: SEL_W] != OUT_SEL_OFF)
                any = 1'b1;
        end
        return any;
    endfunction : out_any_forced

endpackage : contact_io_pkg

/* File: input_force_mux.sv */
// Per-input force selection onto the registered contact input states
`timescale 1ns/1ps
module input_force_mux (
    // Clock and reset
    input  wire logic                                            clk_i,
    input  wire logic                                            rst_n_i,
    // Selectors and sensed states
    input  wire logic [contact_io_pkg::NUM_IN*contact_io_pkg::SEL_W-1:0] sel_i,
    input  wire logic [contact_io_pkg::NUM_IN-1:0]               sensed_i,
    // States seen by the protection logic
    output logic      [contact_io_pkg::NUM_IN-1:0]               state_o
);

    logic [contact_io_pkg::NUM_IN-1:0] state_reg;
    logic [contact_io_pkg::NUM_IN-1:0] state_next;

    // Forced level or sensed level per input
    always_comb begin
        state_next = sensed_i;
        for (int i = 0; i < contact_io_pkg::NUM_IN; i++) begin
            case (sel_i[i*contact_io_pkg::SEL_W +: contact_io_pkg::SEL_W])
                contact_io_pkg::IN_SEL_OPEN:   state_next[i] = 1'b0; // R5
                contact_io_pkg::IN_SEL_CLOSED: state_next[i] = 1'b1; // R5
                default:                       state_next[i] = sensed_i[i]; // R6
            endcase
        end
    end

    // Registered so the consumer never sees a decode glitch
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next; // R4
        end
    end

    assign state_o = state_reg;

endmodule : input_force_mux

/* File: output_force_ctl.sv */
// Per-output force selection with freeze capture onto contact drive
`timescale 1ns/1ps
module output_force_ctl (
    // Clock and reset
    input  wire logic                                              clk_i,
    input  wire logic                                              rst_n_i,
    // Selectors and normally computed drive
    input  wire logic [contact_io_pkg::NUM_OUT*contact_io_pkg::SEL_W-1:0] sel_i,
    input  wire logic [contact_io_pkg::NUM_OUT-1:0]                normal_i,
    // Contact drive
    output logic      [contact_io_pkg::NUM_OUT-1:0]                drive_o
);

    logic [contact_io_pkg::NUM_OUT-1:0] drive_reg;
    logic [contact_io_pkg::NUM_OUT-1:0] drive_next;
    logic [contact_io_pkg::NUM_OUT-1:0] frozen_reg;
    logic [contact_io_pkg::NUM_OUT-1:0] frozen_next;
    logic [contact_io_pkg::NUM_OUT-1:0] was_frz_reg;
    logic [contact_io_pkg::NUM_OUT-1:0] is_frz;

    // Entry into freeze takes the present drive; afterwards the capture holds
    always_comb begin
        drive_next  = normal_i;
        frozen_next = frozen_reg;
        is_frz      = '0;
        for (int i = 0; i < contact_io_pkg::NUM_OUT; i++) begin
            is_frz[i] = sel_i[i*contact_io_pkg::SEL_W +: contact_io_pkg::SEL_W]
                        == contact_io_pkg::OUT_SEL_FREEZE;
            if (is_frz[i] && !was_frz_reg[i])
                frozen_next[i] = drive_reg[i]; // R12
            case (sel_i[i*contact_io_pkg::SEL_W +: contact_io_pkg::SEL_W])
                contact_io_pkg::OUT_SEL_ENERGY: drive_next[i] = 1'b1; // R8
                contact_io_pkg::OUT_SEL_DEENER: drive_next[i] = 1'b0; // R8
                contact_io_pkg::OUT_SEL_FREEZE: drive_next[i] = frozen_next[i]; // R9
                default:                        drive_next[i] = normal_i[i]; // R10
            endcase
        end
    end

    // Drive, capture and freeze history
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            drive_reg   <= '0;
            frozen_reg  <= '0;
            was_frz_reg <= '0;
        end else begin
            drive_reg   <= drive_next; // R7
            frozen_reg  <= frozen_next;
            was_frz_reg <= is_frz;
        end
    end

    assign drive_o = drive_reg;

endmodule : output_force_ctl

/* File: contact_io_test_override_properties.sv */
// Port-level concurrent checks for the contact test override block
`timescale 1ns/1ps
module contact_io_test_override_properties (
    // Clock and reset
    input wire logic        CLK_I,
    input wire logic        RST_N_I,
    // Write channels
    input wire logic        AWVALID_I,
    input wire logic        AWREADY_O,
    input wire logic        WVALID_I,
    input wire logic        WREADY_O,
    input wire logic [1:0]  BRESP_O,
    input wire logic        BVALID_O,
    input wire logic        BREADY_I,
    // Read channels
    input wire logic        ARVALID_I,
    input wire logic        ARREADY_O,
    input wire logic [31:0] RDATA_O,
    input wire logic [1:0]  RRESP_O,
    input wire logic        RVALID_O,
    input wire logic        RREADY_I,
    // Contacts and indicator
    input wire logic [15:0] CONTACT_SENSED_I,
    input wire logic [15:0] CONTACT_STATE_O,
    input wire logic [15:0] OUT_NORMAL_I,
    input wire logic [15:0] CONTACT_DRIVE_O,
    input wire logic        TEST_LED_O
);
    // One domain, so clock and disable are stated once
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    // Two settled cycles out of reset before contact paths are judged
    sequence settled_s;
        $past(RST_N_I) && $past(RST_N_I, 2);
    endsequence

    a_state_normal: assert property (settled_s ##0 !TEST_LED_O |->
        CONTACT_STATE_O == $past(CONTACT_SENSED_I)) else $error("input path not normal");
    a_drive_normal: assert property (settled_s ##0 !TEST_LED_O |->
        CONTACT_DRIVE_O == $past(OUT_NORMAL_I)) else $error("output path not normal");
    a_bresp_holds: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
        else $error("write response dropped");
    a_rdata_holds: assert property (RVALID_O && !RREADY_I |=>
        RVALID_O && $stable(RDATA_O) && $stable(RRESP_O)) else $error("read data dropped");
    a_write_answer: assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O
        |=> BVALID_O) else $error("write not answered");
    a_read_answer: assert property (ARVALID_I && ARREADY_O |=> RVALID_O && !ARREADY_O)
        else $error("read not answered");
    a_write_refuse: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
        else $error("write accepted during response");
    a_write_release: assert property (BVALID_O && BREADY_I |=>
        !BVALID_O && AWREADY_O && WREADY_O) else $error("write channel not released");
    a_error_zero: assert property (RVALID_O && RRESP_O == contact_io_pkg::RESP_SLVERR
        |-> RDATA_O == 32'h0) else $error("error read with data");

    // Main scenarios
    c_led_on: cover property ($rose(TEST_LED_O));
    c_led_off: cover property ($fell(TEST_LED_O));
    c_wr_err: cover property (BVALID_O && BRESP_O == contact_io_pkg::RESP_SLVERR);
    c_rd_err: cover property (RVALID_O && RRESP_O == contact_io_pkg::RESP_SLVERR);
endmodule : contact_io_test_override_properties

bind contact_io_test_override contact_io_test_override_properties u_props (.*);

/* File: contact_io_test_override_tb.sv */
// Self-checking bench for the contact test override block
`timescale 1ns/1ps
module contact_io_test_override_tb;
    // Row of settings, contact inputs and expected results
    typedef struct packed {
        logic        m;
        logic [31:0] isel;
        logic [31:0] osel;
        logic [15:0] sen;
        logic [15:0] nrm;
        logic [15:0] st;
        logic [15:0] dr;
        logic        led;
    } row_t;

    logic        CLK_I, RST_N_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I;
    logic [7:0]  AWADDR_I, ARADDR_I;
    logic [31:0] WDATA_I;
    logic [3:0]  WSTRB_I;
    logic [15:0] CONTACT_SENSED_I, OUT_NORMAL_I;
    wire  logic        AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, TEST_LED_O;
    wire  logic [1:0]  BRESP_O, RRESP_O;
    wire  logic [31:0] RDATA_O;
    wire  logic [15:0] CONTACT_STATE_O, CONTACT_DRIVE_O;
    int          err_total, checks_done;
    row_t        rows [8];

    contact_io_test_override u_dut (
        .CLK_I, .RST_N_I, .AWADDR_I, .AWVALID_I, .AWREADY_O, .WDATA_I, .WSTRB_I, .WVALID_I,
        .WREADY_O, .BRESP_O, .BVALID_O, .BREADY_I, .ARADDR_I, .ARVALID_I, .ARREADY_O,
        .RDATA_O, .RRESP_O, .RVALID_O, .RREADY_I, .CONTACT_SENSED_I, .CONTACT_STATE_O,
        .OUT_NORMAL_I, .CONTACT_DRIVE_O, .TEST_LED_O);

    // 125 MHz clock
    initial begin
        CLK_I = 1'b0;
        forever #4 CLK_I = ~CLK_I;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic hang(input string nm);
        err_total++;
        $display("[FAIL] %s expected handshake seen none", nm);
        close_out();
    endtask : hang

    // Write, both channels offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic       aw, w, b;
        logic [1:0] r;
        b = 1'b0;
        @(posedge CLK_I);
        AWADDR_I  <= a;
        AWVALID_I <= 1'b1;
        WDATA_I   <= d;
        WSTRB_I   <= s;
        WVALID_I  <= 1'b1;
        BREADY_I  <= 1'b1;
        for (int n = 0; n < 40 && !b; n++) begin
            @(negedge CLK_I);
            aw = AWVALID_I & AWREADY_O;
            w  = WVALID_I & WREADY_O;
            b  = BVALID_O;
            r  = BRESP_O;
            @(posedge CLK_I);
            if (aw) AWVALID_I <= 1'b0;
            if (w) WVALID_I <= 1'b0;
        end
        BREADY_I <= 1'b0;
        if (!b) hang("bvalid");
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic        ar, v;
        logic [31:0] d;
        logic [1:0]  r;
        v = 1'b0;
        @(posedge CLK_I);
        ARADDR_I  <= a;
        ARVALID_I <= 1'b1;
        RREADY_I  <= 1'b1;
        for (int n = 0; n < 40 && !v; n++) begin
            @(negedge CLK_I);
            ar = ARVALID_I & ARREADY_O;
            v  = RVALID_O;
            d  = RDATA_O;
            r  = RRESP_O;
            @(posedge CLK_I);
            if (ar) ARVALID_I <= 1'b0;
        end
        RREADY_I <= 1'b0;
        if (!v) hang("rvalid");
        chk("rdata", ed, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask : rd

    // Contacts settle one edge after a write
    task automatic settle(input logic [15:0] es, input logic [15:0] ed, input logic el);
        repeat (3) @(posedge CLK_I);
        @(negedge CLK_I);
        chk("contact_state", {16'h0, es}, {16'h0, CONTACT_STATE_O});
        chk("contact_drive", {16'h0, ed}, {16'h0, CONTACT_DRIVE_O});
        chk("test_led", {31'h0, el}, {31'h0, TEST_LED_O});
    endtask : settle

    // Main sequence
    initial begin
        {AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I} = 5'h0;
        {AWADDR_I, ARADDR_I, WDATA_I, WSTRB_I} = 52'h0;
        CONTACT_SENSED_I = 16'hffff;
        OUT_NORMAL_I     = 16'hffff;
        err_total        = 0;
        checks_done      = 0;
        RST_N_I          = 1'b0;
        rows[0] = '{1'b0, 32'h0, 32'h0, 16'ha5c3, 16'h3c5a, 16'ha5c3, 16'h3c5a, 1'b0};
        rows[1] = '{1'b1, 32'h0, 32'h0, 16'h5a3c, 16'hc3a5, 16'h5a3c, 16'hc3a5, 1'b1};
        rows[2] = '{1'b0, 32'h39, 32'h0, 16'h0005, 16'h0, 16'h0006, 16'h0, 1'b1};
        rows[3] = '{1'b0, 32'haaaa_aaaa, 32'h0, 16'h0, 16'hffff, 16'hffff, 16'hffff, 1'b1};
        rows[4] = '{1'b0, 32'h5555_5555, 32'h0, 16'hffff, 16'h0, 16'h0, 16'h0, 1'b1};
        rows[5] = '{1'b0, 32'h0, 32'h9, 16'h0, 16'h0002, 16'h0, 16'h0001, 1'b1};
        rows[6] = '{1'b0, 32'h0, 32'h5555_5555, 16'h0, 16'h0, 16'h0, 16'hffff, 1'b1};
        rows[7] = '{1'b1, 32'h0, 32'haaaa_aaaa, 16'h1234, 16'hffff, 16'h1234, 16'h0, 1'b1};
        repeat (3) @(posedge CLK_I);
        @(negedge CLK_I);
        chk("ready_in_reset", 32'h7, {29'h0, AWREADY_O, WREADY_O, ARREADY_O});
        chk("led_in_reset", 32'h0, {31'h0, TEST_LED_O});
        chk("state_in_reset", 32'h0, {16'h0, CONTACT_STATE_O});
        @(posedge CLK_I);
        RST_N_I <= 1'b1;
        // Ordinary cases, master written first so its clearing cannot undo new forces
        foreach (rows[i]) begin
            @(posedge CLK_I);
            CONTACT_SENSED_I <= rows[i].sen;
            OUT_NORMAL_I     <= rows[i].nrm;
            wr(contact_io_pkg::OFS_CTRL, {31'h0, rows[i].m}, 4'hf, 2'h0);
            wr(contact_io_pkg::OFS_IN_FORCE, rows[i].isel, 4'hf, 2'h0);
            wr(contact_io_pkg::OFS_OUT_FORCE, rows[i].osel, 4'hf, 2'h0);
            settle(rows[i].st, rows[i].dr, rows[i].led);
            rd(contact_io_pkg::OFS_IN_EFF, {16'h0, rows[i].st}, 2'h0);
        end
        // Master cleared with forces set restores everything at once
        wr(contact_io_pkg::OFS_IN_FORCE, 32'haaaa_aaaa, 4'hf, 2'h0);
        settle(16'hffff, 16'h0, 1'b1);
        wr(contact_io_pkg::OFS_CTRL, 32'h0, 4'hf, 2'h0);
        settle(16'h1234, 16'hffff, 1'b0);
        rd(contact_io_pkg::OFS_OUT_FORCE, 32'h0, 2'h0);
        // Freeze holds the captured drive while the normal drive moves
        @(posedge CLK_I);
        OUT_NORMAL_I <= 16'h00ff;
        wr(contact_io_pkg::OFS_OUT_FORCE, 32'hffff_ffff, 4'hf, 2'h0);
        @(posedge CLK_I);
        OUT_NORMAL_I <= 16'hff00;
        settle(16'h1234, 16'h00ff, 1'b1);
        rd(contact_io_pkg::OFS_STATUS, 32'h5, 2'h0);
        wr(contact_io_pkg::OFS_OUT_FORCE, 32'h0, 4'hf, 2'h0);
        settle(16'h1234, 16'hff00, 1'b0);
        // Byte strobe; code 3 behaves as disabled
        wr(contact_io_pkg::OFS_IN_FORCE, 32'hffff_ffff, 4'h1, 2'h0);
        rd(contact_io_pkg::OFS_IN_FORCE, 32'hff, 2'h0);
        settle(16'h1234, 16'hff00, 1'b0);
        // Read-only and unmapped places
        wr(contact_io_pkg::OFS_IN_SENSED, 32'hffff_ffff, 4'hf, 2'h0);
        rd(contact_io_pkg::OFS_IN_SENSED, 32'h1234, 2'h0);
        wr(8'h20, 32'hffff_ffff, 4'hf, contact_io_pkg::RESP_SLVERR);
        rd(8'h20, 32'h0, contact_io_pkg::RESP_SLVERR);
        close_out();
    end
endmodule : contact_io_test_override_tb
